/* File: logic/eip_top.sv */
// Operation
// - acknowledge high while vector address presented
// - float low forces acknowledge high impedance
// - four lines prioritized, per-line and global mask
// - flag register shows pending lines always
// - non-maskable request ignores both masks
// - non-maskable request uses its own vector
`timescale 1ns/1ps
`default_nettype none
module eip_top
  import eip_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // request inputs, active low
  input  wire logic [3:0]  IRQ_LINES_N,
  input  wire logic        NMI_N,
  // masks and flag clear
  input  wire logic [3:0]  IRQ_MASK,
  input  wire logic        GLOBAL_MASK,
  input  wire logic [3:0]  FLAG_CLEAR,
  // core handshake
  input  wire logic        CORE_READY,
  // output float control, active low
  input  wire logic        FLOAT_N,
  // status
  output logic [3:0]       IRQ_FLAGS,
  output logic             NMI_PENDING,
  // acknowledge pin as two signals, and vector address
  output logic             IRQ_ACK_O,
  output logic             IRQ_ACK_OE_N,
  output logic [15:0]      VEC_ADDR
);

  // sequencer states, one bit so no code is left illegal
  typedef enum logic {ST_IDLE, ST_ACK} eip_state_t;

  eip_state_t  state_reg, state_next;
  logic [3:0]  flags_reg, flags_next;
  logic [3:0]  lines_reg;
  logic        nmi_in_reg, nmi_pend_reg, nmi_pend_next;
  logic [1:0]  cnt_reg, cnt_next;
  eip_src_t    src_reg, src_next;
  eip_ack_t    ack_reg, ack_next;
  logic        win_any;
  logic [1:0]  win_idx;
  logic [3:0]  enabled;
  logic        nmi_edge;

  // input sampling registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      lines_reg  <= 4'hF;
      nmi_in_reg <= 1'b1;
    end else begin
      lines_reg  <= IRQ_LINES_N;
      nmi_in_reg <= NMI_N;
    end
  end

  // falling edge of the non-maskable request
  assign nmi_edge = nmi_in_reg & ~NMI_N;

  assign enabled = flags_reg & IRQ_MASK & {4{~GLOBAL_MASK}};

  eip_prio u_prio (
    .req (enabled),
    .any (win_any),
    .idx (win_idx)
  );

  // next state of flags, sequencer and acknowledge
  always_comb begin
    flags_next    = flags_reg;
    nmi_pend_next = nmi_pend_reg;
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    src_next      = src_reg;
    ack_next      = ack_reg;
    flags_next    = flags_next & ~FLAG_CLEAR;
    unique case (state_reg)
      ST_IDLE: begin
        ack_next.ack = 1'b0;
        if (nmi_pend_reg && CORE_READY) begin
          nmi_pend_next     = 1'b0;
          src_next          = '{is_nmi: 1'b1, line: 2'h0};
          ack_next.vec_addr = EIP_VEC_NMI;
          ack_next.ack      = 1'b1;
          cnt_next          = EIP_ACK_CYCLES - 2'h1;
          state_next        = ST_ACK;
        end else if (win_any && CORE_READY) begin
          flags_next[win_idx] = 1'b0;
          src_next          = '{is_nmi: 1'b0, line: win_idx};
          ack_next.vec_addr = EIP_VEC_BASE + (16'(win_idx) * EIP_VEC_STEP);
          ack_next.ack      = 1'b1;
          cnt_next          = EIP_ACK_CYCLES - 2'h1;
          state_next        = ST_ACK;
        end
      end
      ST_ACK: begin
        if (cnt_reg == 2'h0) begin
          ack_next.ack = 1'b0;
          state_next   = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
    endcase
    // latch pending lines regardless of mask
    flags_next = flags_next | ~lines_reg;
    if (nmi_edge) begin
      nmi_pend_next = 1'b1;
    end
    ack_next.ack_oe_n = ~FLOAT_N;
  end

  // state registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg    <= ST_IDLE;
      flags_reg    <= EIP_FLAGS_RST;
      nmi_pend_reg <= 1'b0;
      cnt_reg      <= 2'h0;
      src_reg      <= '0;
      ack_reg      <= '{ack: 1'b0, ack_oe_n: 1'b1, vec_addr: EIP_ADDR_RST};
    end else begin
      state_reg    <= state_next;
      flags_reg    <= flags_next;
      nmi_pend_reg <= nmi_pend_next;
      cnt_reg      <= cnt_next;
      src_reg      <= src_next;
      ack_reg      <= ack_next;
    end
  end

  // outputs straight from flip-flops
  assign IRQ_FLAGS    = flags_reg;
  assign NMI_PENDING  = nmi_pend_reg;
  assign IRQ_ACK_O    = ack_reg.ack;
  assign IRQ_ACK_OE_N = ack_reg.ack_oe_n;
  assign VEC_ADDR     = ack_reg.vec_addr;

  // checks on float control, masking, flags and the acknowledge sequence
  // float gives high z
  a_ack_float: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !FLOAT_N |=> IRQ_ACK_OE_N)
    else $error("acknowledge driven while float low");

  a_ack_drive: assert property (@(posedge SYS_CLK) disable iff (RESET)
    FLOAT_N |=> !IRQ_ACK_OE_N)
    else $error("acknowledge floated while float high");

  a_ack_len: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $rose(IRQ_ACK_O) |-> IRQ_ACK_O [*2] ##1 !IRQ_ACK_O)
    else $error("acknowledge length wrong");

  a_ack_vec: assert property (@(posedge SYS_CLK) disable iff (RESET)
    IRQ_ACK_O |-> $stable(VEC_ADDR) || $rose(IRQ_ACK_O))
    else $error("vector moved during acknowledge");

  a_src_line: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IRQ_ACK_O && !src_reg.is_nmi) |->
      VEC_ADDR == EIP_VEC_BASE + EIP_VEC_STEP * 16'(src_reg.line))
    else $error("line vector does not match source");

  a_mask_block: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_reg == ST_IDLE && GLOBAL_MASK && !nmi_pend_reg) |=> !IRQ_ACK_O)
    else $error("masked request acknowledged");

  a_prio_pick: assert property (@(posedge SYS_CLK) disable iff (RESET)
    ($rose(IRQ_ACK_O) && !src_reg.is_nmi) |->
      ((($past(enabled) >> src_reg.line) & 4'h1) == 4'h1) &&
      (($past(enabled) & ((4'h1 << src_reg.line) - 4'h1)) == 4'h0))
    else $error("wrong line acknowledged");

  a_flag_set: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!lines_reg[0]) |=> IRQ_FLAGS[0])
    else $error("pending line not flagged");

  a_nmi_latch: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (nmi_in_reg && !NMI_N) |=> NMI_PENDING)
    else $error("nmi request lost");

  a_nmi_take: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_reg == ST_IDLE && nmi_pend_reg && CORE_READY) |=> IRQ_ACK_O)
    else $error("nmi not accepted");

  a_nmi_vec: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (state_reg == ST_IDLE && nmi_pend_reg && CORE_READY) |=> VEC_ADDR == EIP_VEC_NMI)
    else $error("nmi vector wrong");

  a_src_nmi: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IRQ_ACK_O && src_reg.is_nmi) |-> VEC_ADDR == EIP_VEC_NMI)
    else $error("nmi source with line vector");

  a_flag_hold: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (IRQ_FLAGS[1] && !FLAG_CLEAR[1] && state_reg == ST_ACK) |=> IRQ_FLAGS[1])
    else $error("flag dropped without clear");

  a_flag_clear: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (FLAG_CLEAR[0] && lines_reg[0]) |=> !IRQ_FLAGS[0])
    else $error("flag kept after clear");

endmodule : eip_top
`default_nettype wire

/* File: logic/eip_pkg.sv */
package eip_pkg;

  // number of maskable external request lines
  localparam int unsigned EIP_NUM_IRQ = 4;

  // vector addresses presented on the low address lines during acknowledge
  localparam logic [15:0] EIP_VEC_BASE  = 16'hFFC0;
  localparam logic [15:0] EIP_VEC_STEP  = 16'h0004;
  localparam logic [15:0] EIP_VEC_NMI   = 16'hFF88;

  // cycles the acknowledge stays asserted while the vector is fetched
  localparam logic [1:0]  EIP_ACK_CYCLES = 2'h2;

  // reset values
  localparam logic [3:0]  EIP_FLAGS_RST = 4'h0;
  localparam logic [15:0] EIP_ADDR_RST  = 16'h0000;

  // source of an accepted request
  typedef struct packed {
    logic        is_nmi;
    logic [1:0]  line;
  } eip_src_t;

  // acknowledge bus towards the core and address pins
  typedef struct packed {
    logic        ack;
    logic        ack_oe_n;
    logic [15:0] vec_addr;
  } eip_ack_t;

endpackage : eip_pkg

/* File: logic/eip_prio.sv */
`timescale 1ns/1ps
`default_nettype none
module eip_prio
  import eip_pkg::*;
(
  // requests, already masked
  input  wire logic [3:0] req,
  // winner
  output logic            any,
  output logic [1:0]      idx
);

  // lowest numbered line wins
  always_comb begin
    any = 1'b0;
    idx = 2'h0;
    for (int i = EIP_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 2'(i);
      end
    end
  end

endmodule : eip_prio
`default_nettype wire

/* File: tb/eip_periph.sv */
`timescale 1ns/1ps
`default_nettype none
// request sources: pulled-up lines, pulled low one cycle per fire
module eip_periph (
  input  wire logic       clk,
  input  wire logic [3:0] fire,
  input  wire logic       fire_nmi,
  output logic [3:0]      lines_n,
  output logic            nmi_n
);
  // lines start idle high and change at the falling edge
  initial begin
    lines_n = 4'hF;
    nmi_n   = 1'h1;
    forever begin
      @(negedge clk);
      lines_n <= ~fire;
      nmi_n   <= ~fire_nmi;
    end
  end
endmodule : eip_periph
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eip_pkg::*;
  logic        sys_clk, reset, nmi_n, gmask, ready, float_n, fire_nmi, nmi_pend, ack, oe_n;
  logic [3:0]  lines_n, mask, fclr, fire, flags, p, en;
  logic [15:0] vec;
  int          num_errors, n_checks, seed, i;
  eip_periph PER (.clk(sys_clk), .fire(fire), .fire_nmi(fire_nmi), .lines_n(lines_n),
                  .nmi_n(nmi_n));
  eip_top DUT (.SYS_CLK(sys_clk), .RESET(reset), .IRQ_LINES_N(lines_n), .NMI_N(nmi_n),
               .IRQ_MASK(mask), .GLOBAL_MASK(gmask), .FLAG_CLEAR(fclr), .CORE_READY(ready),
               .FLOAT_N(float_n), .IRQ_FLAGS(flags), .NMI_PENDING(nmi_pend),
               .IRQ_ACK_O(ack), .IRQ_ACK_OE_N(oe_n), .VEC_ADDR(vec));
  // clock
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  task summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // lowest set index wins
  function automatic logic [15:0] low_idx(input logic [3:0] v);
    low_idx = 16'h0;
    for (int j = 3; j >= 0; j--) if (v[j]) low_idx = 16'(j);
  endfunction : low_idx
  // bounded wait for acknowledge, then vector, drive state and length
  task wait_ack(input logic [15:0] ev);
    int k;
    k = 0;
    while (ack !== 1'h1 && k < 12) begin
      cyc(1);
      k++;
    end
    if (ack !== 1'h1) begin
      num_errors++;
      $display("wrong value ack exp 1 got 0");
      disable body;
    end
    chk("vec", ev, vec);
    chk("oe_n", {15'h0, ~float_n}, {15'h0, oe_n});
    cyc(1);
    chk("ack 2nd", 16'h1, {15'h0, ack});
    cyc(1);
    chk("ack end", 16'h0, {15'h0, ack});
  endtask : wait_ack
  initial begin
    seed = 76; num_errors = 0; n_checks = 0; reset = 1'h1; mask = 4'h0; gmask = 1'h0;
    fclr = 4'h0; ready = 1'h0; float_n = 1'h1; fire = 4'h0; fire_nmi = 1'h0;
    // a timed-out wait leaves this block and goes straight to the report
    begin : body
      cyc(6);
      reset = 1'h0;
      chk("rst flags", 16'h0, {12'h0, flags});
      chk("rst oe_n", 16'h1, {15'h0, oe_n});
      chk("rst vec", EIP_ADDR_RST, vec);
      chk("rst ack", 16'h0, {15'h0, ack});
      chk("rst nmi_pend", 16'h0, {15'h0, nmi_pend});
      // random pulses under random masks, single lines first
      for (i = 0; i < 40; i++) begin
        p = (i < 4) ? (4'h1 << i) : 4'($random(seed));
        mask = (i < 4) ? 4'hF : 4'($random(seed));
        gmask = (i % 5 == 4);
        fire <= p;
        cyc(1);
        fire <= 4'h0;
        cyc(4);
        chk("flags", {12'h0, p}, {12'h0, flags});
        en = gmask ? 4'h0 : (p & mask);
        ready = 1'h1;
        if (en != 4'h0) wait_ack(EIP_VEC_BASE + EIP_VEC_STEP * low_idx(en));
        else begin
          cyc(6);
          chk("masked ack", 16'h0, {15'h0, ack});
        end
        ready = 1'h0;
        cyc(3);
        fclr = 4'hF;
        cyc(1);
        fclr = 4'h0;
        cyc(1);
        chk("cleared", 16'h0, {12'h0, flags});
      end
      $display("test random lines done");
      // non-maskable with all masks set, then again floated
      gmask = 1'h1;
      mask = 4'h0;
      repeat (2) begin
        ready = 1'h0;
        fire_nmi <= 1'h1;
        cyc(1);
        fire_nmi <= 1'h0;
        cyc(1);
        chk("nmi_pend", 16'h1, {15'h0, nmi_pend});
        ready = 1'h1;
        wait_ack(EIP_VEC_NMI);
        chk("nmi_pend end", 16'h0, {15'h0, nmi_pend});
        float_n = 1'h0;
        cyc(3);
        chk("float oe_n", 16'h1, {15'h0, oe_n});
      end
      float_n = 1'h1;
      cyc(2);
      chk("drive oe_n", 16'h0, {15'h0, oe_n});
      $display("test nmi and float done");
    end
    summarize();
  end
endmodule : tb_top
`default_nettype wire
